// File: common/ppcc_pkg.sv
/*
 * ppcc_pkg: constants, register map and field layouts of the pulse position command block.
 * assumes a single 20 MHz clock and a 32-bit AXI4-Lite register bus.
 */
package ppcc_pkg;
    localparam int CLK_PERIOD_NS = 50;
    localparam int SAMPLE_NS     = 100000;
    localparam int SAMPLE_CYCLES = (SAMPLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam logic [7:0] ADDR_MODE_SEL   = 8'h00;
    localparam logic [7:0] ADDR_PULSE_CFG  = 8'h04;
    localparam logic [7:0] ADDR_GAIN_HOLD  = 8'h08;
    localparam logic [7:0] ADDR_GAIN_DYN   = 8'h0c;
    localparam logic [7:0] ADDR_GAIN_MODE  = 8'h10;
    localparam logic [7:0] ADDR_TORQUE_LVL = 8'h14;
    localparam logic [7:0] ADDR_SPEED_LVL  = 8'h18;
    localparam logic [7:0] ADDR_SMOOTH     = 8'h1c;
    localparam logic [7:0] ADDR_OUT_LIMIT  = 8'h20;
    localparam logic [7:0] ADDR_DIG_POS    = 8'h24;
    localparam logic [7:0] ADDR_STATUS     = 8'h28;
    localparam logic [7:0] ADDR_COUNT      = 8'h2c;
    localparam logic [7:0] ADDR_RATE       = 8'h30;

    localparam logic [15:0] RST_MODE_SEL   = 16'h0000;
    localparam logic [15:0] RST_PULSE_CFG  = 16'h0000;
    localparam logic [15:0] RST_GAIN_HOLD  = 16'h00c8;
    localparam logic [15:0] RST_GAIN_DYN   = 16'h012c;
    localparam logic [15:0] RST_GAIN_MODE  = 16'h0000;
    localparam logic [15:0] RST_TORQUE_LVL = 16'h0064;
    localparam logic [15:0] RST_SPEED_LVL  = 16'h0064;
    localparam logic [3:0]  RST_SMOOTH     = 4'h5;
    localparam logic [15:0] RST_OUT_LIMIT  = 16'h00c8;
    localparam logic [15:0] RST_DIG_POS    = 16'h0000;

    localparam logic [15:0] GAIN_MAX       = 16'h0fa0;
    localparam logic [15:0] LEVEL_MAX      = 16'h03e8;
    localparam logic signed [15:0] OVERSPEED_MAX = 16'sh01f4;

    localparam logic [3:0] CTRL_POSITION = 4'h1;
    localparam logic [3:0] SRC_PULSE     = 4'h0;
    localparam logic [3:0] SRC_DIGITAL   = 4'h1;
    localparam logic [3:0] SRC_PHOTO     = 4'h2;
    localparam logic [15:0] GMODE_NONE   = 16'h0000;
    localparam logic [15:0] GMODE_TORQUE = 16'h0001;
    localparam logic [15:0] GMODE_SPEED  = 16'h0002;

    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_DECERR = 2'b11;

    typedef enum logic [3:0] {
        PM_QUADRATURE = 4'h0,
        PM_PULSE_SIGN = 4'h1,
        PM_POSITIVE   = 4'h2,
        PM_DUAL       = 4'h3
    } ppcc_pulse_mode_type;

    typedef struct packed {
        logic [3:0] servo;
        logic [3:0] reserved;
        logic [3:0] source;
        logic [3:0] control;
    } ppcc_mode_sel_type;

    typedef struct packed {
        logic [1:0]          ctl_reserved;
        logic                overspeed_on;
        logic                avg_filter;
        logic [3:0]          reserved;
        logic [1:0]          dir_reserved;
        logic                dir_follow_run;
        logic                dir_reverse;
        ppcc_pulse_mode_type pulse_mode;
    } ppcc_pulse_cfg_type;
endpackage

// File: logic/ppcc_top.sv
/*
 * ppcc_top: position command front end with AXI4-Lite registers, pulse decoder,
 * command filter, gain switching and regulator output limit.
 * assumes pins are asynchronous; command, torque and regulator values come from the same clock.
 */
`timescale 1ns/1ps
module ppcc_top
    import ppcc_pkg::*;
(
    input  wire logic               clk,
    input  wire logic               nrst,
    input  wire logic [7:0]         s_axi_awaddr,
    input  wire logic               s_axi_awvalid,
    output logic                    s_axi_awready,
    input  wire logic [31:0]        s_axi_wdata,
    input  wire logic [3:0]         s_axi_wstrb,
    input  wire logic               s_axi_wvalid,
    output logic                    s_axi_wready,
    output logic [1:0]              s_axi_bresp,
    output logic                    s_axi_bvalid,
    input  wire logic               s_axi_bready,
    input  wire logic [7:0]         s_axi_araddr,
    input  wire logic               s_axi_arvalid,
    output logic                    s_axi_arready,
    output logic [31:0]             s_axi_rdata,
    output logic [1:0]              s_axi_rresp,
    output logic                    s_axi_rvalid,
    input  wire logic               s_axi_rready,
    input  wire logic               pulse_channel_a,
    input  wire logic               pulse_channel_b,
    input  wire logic               photo_switch,
    input  wire logic               servo_enable,
    input  wire logic               forward_run_command,
    input  wire logic               reverse_run_command,
    input  wire logic               closed_loop_vector_mode,
    input  wire logic               spindle_orientation,
    input  wire logic               orientation_locked,
    input  wire logic [15:0]        torque_command,
    input  wire logic [15:0]        speed_command,
    input  wire logic signed [15:0] regulator_in,
    output logic                    position_control_active,
    output logic [3:0]              command_source,
    output logic                    stop_positioning_start,
    output logic [15:0]             stop_distance,
    output logic                    servo_running,
    output logic signed [31:0]      pulse_count,
    output logic signed [15:0]      pulse_rate,
    output logic [15:0]             gain_active,
    output logic                    gain_dynamic_selected,
    output logic signed [15:0]      regulator_out,
    output logic                    regulator_enable
);
    ppcc_mode_sel_type  mode_sel;
    ppcc_pulse_cfg_type pulse_cfg;
    logic [15:0]        gain_hold;
    logic [15:0]        gain_dyn;
    logic [15:0]        gain_mode;
    logic [15:0]        torque_lvl;
    logic [15:0]        speed_lvl;
    logic [3:0]         smooth;
    logic [15:0]        out_limit;
    logic [15:0]        dig_pos;
    logic [7:0]         awaddr_q;
    logic [31:0]        wdata_q;
    logic [3:0]         wstrb_q;
    logic [6:0]         sync1;
    logic [6:0]         sync2;
    logic [2:0]         prev;
    logic [10:0]        tick_cnt;
    logic signed [15:0] win_acc;
    logic signed [15:0] hist [3];
    logic signed [15:0] rate_inertia;

    function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] lim);
        logic [15:0] v;
        v = {wstrb_q[1] ? wdata_q[15:8] : old[15:8], wstrb_q[0] ? wdata_q[7:0] : old[7:0]};
        return (v > lim) ? lim : v;
    endfunction

    // bus write and read decode
    wire wr_fire = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
    wire wr_ok   = (awaddr_q[1:0] == 2'b00) && (awaddr_q <= ADDR_RATE);
    wire rd_ok   = (s_axi_araddr[1:0] == 2'b00) && (s_axi_araddr <= ADDR_RATE);
    wire [31:0] status_word = {28'h0000000, gain_dynamic_selected, regulator_enable,
                               servo_running, position_control_active};
    logic [31:0] rd_word;
    always_comb
    begin
        case (s_axi_araddr)
            ADDR_MODE_SEL:   rd_word = {16'h0000, mode_sel};
            ADDR_PULSE_CFG:  rd_word = {16'h0000, pulse_cfg};
            ADDR_GAIN_HOLD:  rd_word = {16'h0000, gain_hold};
            ADDR_GAIN_DYN:   rd_word = {16'h0000, gain_dyn};
            ADDR_GAIN_MODE:  rd_word = {16'h0000, gain_mode};
            ADDR_TORQUE_LVL: rd_word = {16'h0000, torque_lvl};
            ADDR_SPEED_LVL:  rd_word = {16'h0000, speed_lvl};
            ADDR_SMOOTH:     rd_word = {28'h0000000, smooth};
            ADDR_OUT_LIMIT:  rd_word = {16'h0000, out_limit};
            ADDR_DIG_POS:    rd_word = {16'h0000, dig_pos};
            ADDR_STATUS:     rd_word = status_word;
            ADDR_COUNT:      rd_word = pulse_count;
            ADDR_RATE:       rd_word = {{16{pulse_rate[15]}}, pulse_rate};
            default:         rd_word = 32'h00000000;
        endcase
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
            awaddr_q      <= 8'h00;
            wdata_q       <= 32'h00000000;
            wstrb_q       <= 4'h0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                awaddr_q      <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                wdata_q      <= s_axi_wdata;
                wstrb_q      <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_fire)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_ok ? RESP_OKAY : RESP_DECERR;
            end
            else if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            mode_sel   <= RST_MODE_SEL;
            pulse_cfg  <= RST_PULSE_CFG;
            gain_hold  <= RST_GAIN_HOLD;
            gain_dyn   <= RST_GAIN_DYN;
            gain_mode  <= RST_GAIN_MODE;
            torque_lvl <= RST_TORQUE_LVL;
            speed_lvl  <= RST_SPEED_LVL;
            smooth     <= RST_SMOOTH;
            out_limit  <= RST_OUT_LIMIT;
            dig_pos    <= RST_DIG_POS;
        end
        else if (wr_fire)
        begin
            case (awaddr_q)
                ADDR_MODE_SEL:   mode_sel   <= merge(mode_sel, 16'hffff);
                ADDR_PULSE_CFG:  pulse_cfg  <= merge(pulse_cfg, 16'hffff);
                ADDR_GAIN_HOLD:  gain_hold  <= merge(gain_hold, GAIN_MAX);
                ADDR_GAIN_DYN:   gain_dyn   <= merge(gain_dyn, GAIN_MAX);
                ADDR_GAIN_MODE:  gain_mode  <= merge(gain_mode, 16'hffff);
                ADDR_TORQUE_LVL: torque_lvl <= merge(torque_lvl, LEVEL_MAX);
                ADDR_SPEED_LVL:  speed_lvl  <= merge(speed_lvl, LEVEL_MAX);
                ADDR_SMOOTH:     smooth     <= wstrb_q[0] ? wdata_q[3:0] : smooth;
                ADDR_OUT_LIMIT:  out_limit  <= merge(out_limit, LEVEL_MAX);
                ADDR_DIG_POS:    dig_pos    <= merge(dig_pos, 16'hffff);
                default:         mode_sel   <= mode_sel;
            endcase
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_word;
            s_axi_rresp   <= rd_ok ? RESP_OKAY : RESP_DECERR;
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // pin synchronisers; prev holds the last synchronised a, b and photo levels
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            sync1 <= 7'h00;
            sync2 <= 7'h00;
            prev  <= 3'h0;
        end
        else
        begin
            sync1 <= {pulse_channel_a, pulse_channel_b, photo_switch, servo_enable,
                      forward_run_command, reverse_run_command, closed_loop_vector_mode};
            sync2 <= sync1;
            prev  <= sync2[6:4];
        end
    end

    wire a_s    = sync2[6];
    wire b_s    = sync2[5];
    wire a_rise = a_s && !prev[2];
    wire b_rise = b_s && !prev[1];
    wire photo_rise  = sync2[4] && !prev[0];
    wire servo_en_s  = sync2[3];
    wire run_s       = sync2[2] || sync2[1];
    wire rev_s       = sync2[1];
    wire clvm_s      = sync2[0];
    wire quad_step   = (a_s ^ prev[2]) ^ (b_s ^ prev[1]);
    wire quad_up     = a_s ^ prev[1];
    wire mode_step   = (pulse_cfg.pulse_mode == PM_QUADRATURE) ? quad_step :
                       (pulse_cfg.pulse_mode == PM_PULSE_SIGN) ? a_rise :
                       (pulse_cfg.pulse_mode == PM_POSITIVE)   ? a_rise :
                       (pulse_cfg.pulse_mode == PM_DUAL)       ? a_rise ^ b_rise : 1'b0;
    wire mode_up     = (pulse_cfg.pulse_mode == PM_QUADRATURE) ? quad_up :
                       (pulse_cfg.pulse_mode == PM_PULSE_SIGN) ? !b_s :
                       (pulse_cfg.pulse_mode == PM_DUAL)       ? a_rise : 1'b1;
    wire reverse_sense = pulse_cfg.dir_follow_run ? rev_s : pulse_cfg.dir_reverse;
    wire count_up    = mode_up ^ reverse_sense;
    wire signed [15:0] step_val = !mode_step ? 16'sh0000 : count_up ? 16'sh0001 : -16'sh0001;
    wire tick        = (tick_cnt == 11'(SAMPLE_CYCLES - 1));

    // command filter and overspeed clamp
    wire signed [17:0] avg_sum  = 18'(win_acc) + 18'(hist[0]) + 18'(hist[1]) + 18'(hist[2]);
    wire signed [16:0] in_diff  = 17'(win_acc) - 17'(rate_inertia);
    wire signed [15:0] next_inertia = rate_inertia + 16'(in_diff >>> 2);
    wire signed [15:0] filt     = pulse_cfg.avg_filter ? 16'(avg_sum >>> 2) : next_inertia;
    wire signed [15:0] next_rate = !pulse_cfg.overspeed_on ? filt :
                                   (filt > OVERSPEED_MAX) ? OVERSPEED_MAX :
                                   (filt < -OVERSPEED_MAX) ? -OVERSPEED_MAX : filt;

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            tick_cnt     <= 11'h000;
            pulse_count  <= 32'sh00000000;
            win_acc      <= 16'sh0000;
            hist         <= '{default: 16'sh0000};
            rate_inertia <= 16'sh0000;
            pulse_rate   <= 16'sh0000;
        end
        else
        begin
            tick_cnt    <= tick ? 11'h000 : tick_cnt + 11'h001;
            pulse_count <= pulse_count + 32'(step_val);
            if (tick)
            begin
                win_acc      <= step_val;
                hist         <= '{win_acc, hist[0], hist[1]};
                rate_inertia <= next_inertia;
                pulse_rate   <= next_rate;
            end
            else
            begin
                win_acc <= win_acc + step_val;
            end
        end
    end

    // gain selection and smoothing
    wire torque_high = torque_command >= torque_lvl;
    wire speed_high  = speed_command >= speed_lvl;
    wire mode_dyn    = (gain_mode == GMODE_TORQUE) ? torque_high :
                       (gain_mode == GMODE_SPEED)  ? speed_high : 1'b0;
    wire use_dyn     = spindle_orientation ? !orientation_locked : mode_dyn;
    wire [15:0] gain_target = use_dyn ? gain_dyn : gain_hold;
    wire signed [16:0] g_diff  = 17'(gain_target) - 17'(gain_active);
    wire signed [16:0] g_shift = g_diff >>> smooth;
    wire signed [16:0] g_step  = (g_shift == 17'sh00000 && g_diff != 17'sh00000) ?
                                 ((g_diff > 17'sh00000) ? 17'sh00001 : -17'sh00001) : g_shift;
    wire signed [16:0] limit_s = 17'(out_limit);
    wire signed [16:0] reg_s   = 17'(regulator_in);
    wire signed [15:0] next_reg_out = (out_limit == 16'h0000) ? 16'sh0000 :
                                      (reg_s > limit_s) ? 16'(limit_s) :
                                      (reg_s < -limit_s) ? 16'(-limit_s) : regulator_in;
    wire next_pos_active = clvm_s && (mode_sel.control == CTRL_POSITION);

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            gain_active             <= RST_GAIN_HOLD;
            gain_dynamic_selected   <= 1'b0;
            position_control_active <= 1'b0;
            command_source          <= SRC_PULSE;
            stop_positioning_start  <= 1'b0;
            stop_distance           <= RST_DIG_POS;
            servo_running           <= 1'b0;
            regulator_out           <= 16'sh0000;
            regulator_enable        <= 1'b0;
        end
        else
        begin
            if (tick)
            begin
                gain_active <= 16'(17'(gain_active) + g_step);
            end
            gain_dynamic_selected   <= use_dyn;
            position_control_active <= next_pos_active;
            command_source          <= mode_sel.source;
            stop_positioning_start  <= photo_rise && (mode_sel.source == SRC_PHOTO);
            stop_distance           <= dig_pos;
            servo_running           <= (mode_sel.servo != 4'h0) && (servo_en_s || run_s);
            regulator_out           <= next_pos_active ? next_reg_out : 16'sh0000;
            regulator_enable        <= next_pos_active && (out_limit != 16'h0000);
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);

    ctrl_mode_a: assert property (clvm_s && mode_sel.control == CTRL_POSITION |=> position_control_active)
        else $error("position control not selected");
    source_out_a: assert property (1'b1 |=> command_source == $past(mode_sel.source))
        else $error("command source mismatch");
    photo_stop_a: assert property (stop_positioning_start |-> mode_sel.source == SRC_PHOTO || $past(mode_sel.source) == SRC_PHOTO)
        else $error("stop positioning without photo source");
    servo_run_a: assert property (mode_sel.servo != 4'h0 && servo_en_s && $stable(mode_sel) |=> servo_running)
        else $error("servo running missed");
    sign_mode_a: assert property (pulse_cfg.pulse_mode == PM_PULSE_SIGN && !reverse_sense && a_rise && b_s
        |=> pulse_count == $past(pulse_count) - 32'sh00000001)
        else $error("pulse sign count wrong");
    positive_mode_a: assert property (pulse_cfg.pulse_mode == PM_POSITIVE && !a_rise |=> pulse_count == $past(pulse_count))
        else $error("count moved without channel a edge");
    fixed_dir_a: assert property (pulse_cfg.pulse_mode == PM_POSITIVE && !pulse_cfg.dir_follow_run && pulse_cfg.dir_reverse
        && a_rise |=> pulse_count == $past(pulse_count) - 32'sh00000001)
        else $error("fixed direction not applied");
    overspeed_a: assert property (pulse_cfg.overspeed_on && $stable(pulse_cfg) && tick
        |=> pulse_rate <= OVERSPEED_MAX && pulse_rate >= -OVERSPEED_MAX)
        else $error("overspeed clamp failed");
    orient_gain_a: assert property (spindle_orientation && !orientation_locked |=> gain_dynamic_selected)
        else $error("orientation gain not dynamic");
    limit_zero_a: assert property (out_limit == 16'h0000 |=> !regulator_enable && regulator_out == 16'sh0000)
        else $error("regulator active with zero limit");
    gain_max_a: assert property (gain_hold <= GAIN_MAX && gain_dyn <= GAIN_MAX)
        else $error("gain above maximum");
endmodule // ppcc_top

// File: testbench/ppcc_pulse_source.sv
/*
 * ppcc_pulse_source: upper controller model driving the two pulse command channels.
 * assumes the bench calls put; each new level is held for four clocks.
 */
`timescale 1ns/1ps
module ppcc_pulse_source (
    input  wire logic clk,
    output logic      pulse_channel_a,
    output logic      pulse_channel_b
);
    initial
    begin
        pulse_channel_a = 1'b0;
        pulse_channel_b = 1'b0;
    end
    // drives one step of the selected pulse format
    task automatic put(input logic [1:0] ab);
        @(posedge clk);
        pulse_channel_a <= ab[1];
        pulse_channel_b <= ab[0];
        repeat (3) @(posedge clk);
    endtask
endmodule // ppcc_pulse_source

// File: testbench/tb.sv
/*
 * tb: register, pulse decoding, gain and regulator checks for ppcc_top.
 * assumes one 50 ns clock and the pulse source model beside the design.
 */
`timescale 1ns/1ps
module tb
    import ppcc_pkg::*;
;
    logic               clk, nrst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic               s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, seen;
    logic               pulse_channel_a, pulse_channel_b, photo_switch, servo_enable, forward_run_command;
    logic               reverse_run_command, closed_loop_vector_mode, spindle_orientation, orientation_locked;
    logic               position_control_active, stop_positioning_start, servo_running, gain_dynamic_selected;
    logic               regulator_enable;
    logic [7:0]         s_axi_awaddr, s_axi_araddr;
    logic [3:0]         s_axi_wstrb, command_source;
    logic [1:0]         s_axi_bresp, s_axi_rresp, rd_resp;
    logic [31:0]        s_axi_wdata, s_axi_rdata, rd_data, exp_cnt;
    logic [15:0]        torque_command, speed_command, stop_distance, gain_active;
    logic signed [15:0] regulator_in, regulator_out, pulse_rate;
    logic signed [31:0] pulse_count;
    int                 checks, failures, cyc;
    localparam logic [7:0]  rst_addr [5] = '{ADDR_MODE_SEL, ADDR_PULSE_CFG, ADDR_GAIN_MODE, ADDR_GAIN_HOLD, ADDR_GAIN_DYN};
    localparam logic [31:0] rst_val [5]  = '{32'h0, 32'h0, 32'h0, 32'h00c8, 32'h012c};
    localparam logic [15:0] pcfg [6] = '{16'h0000, 16'h0001, 16'h0002, 16'h0003, 16'h0010, 16'h0021};
    localparam logic [31:0] pdel [6] = '{32'h4, 32'h2, 32'h2, 32'h1, 32'hfffffffc, 32'hfffffffe};
    localparam logic [1:0]  pat [6]  = '{2'b10, 2'b11, 2'b01, 2'b00, 2'b10, 2'b00};

    ppcc_top dut (.*);
    ppcc_pulse_source src (.clk, .pulse_channel_a, .pulse_channel_b);

    task automatic chk(input string n, input logic [31:0] seen_v, input logic [31:0] exp_v);
        checks++;
        if (seen_v !== exp_v)
        begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", n, exp_v, seen_v);
        end
    endtask
    task automatic results;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        {s_axi_awaddr, s_axi_wdata} <= {a, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
        do
        begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'b11;
        do
        begin
            @(posedge clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        {rd_data, rd_resp} = {s_axi_rdata, s_axi_rresp};
        s_axi_rready <= 1'b0;
    endtask

    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            failures++;
            results();
        end
    end

    initial
    begin
        {nrst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, photo_switch} = '0;
        {servo_enable, forward_run_command, reverse_run_command, spindle_orientation, orientation_locked} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, torque_command, speed_command, exp_cnt} = '0;
        s_axi_wstrb = 4'hf;
        closed_loop_vector_mode = 1'b1;
        regulator_in = 16'sh0200;
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        foreach (rst_addr[i])
        begin
            rd(rst_addr[i]);
            chk("reset value", rd_data, rst_val[i]);
        end
        chk("gain reset", gain_active, 16'h00c8);
        rd(8'h34);
        chk("unmapped response", rd_resp, RESP_DECERR);
        wr(ADDR_GAIN_HOLD, 32'hffff);
        rd(ADDR_GAIN_HOLD);
        chk("gain ceiling", rd_data, GAIN_MAX);
        wr(ADDR_MODE_SEL, 32'h0001);
        repeat (4) @(posedge clk);
        chk("position on", position_control_active, 1'b1);
        closed_loop_vector_mode <= 1'b0;
        repeat (4) @(posedge clk);
        chk("position off", position_control_active, 1'b0);
        closed_loop_vector_mode <= 1'b1;
        wr(ADDR_OUT_LIMIT, 32'h0064);
        repeat (4) @(posedge clk);
        chk("clamp high", regulator_out, 16'h0064);
        regulator_in <= -16'sh0200;
        repeat (3) @(posedge clk);
        chk("clamp low", regulator_out, 32'hffffff9c);
        wr(ADDR_OUT_LIMIT, 32'h0);
        repeat (3) @(posedge clk);
        chk("regulator off", regulator_enable, 1'b0);
        wr(ADDR_GAIN_MODE, 32'h0001);
        torque_command <= 16'h0200;
        repeat (4) @(posedge clk);
        chk("torque switch", gain_dynamic_selected, 1'b1);
        torque_command <= 16'h0010;
        repeat (4) @(posedge clk);
        chk("torque below", gain_dynamic_selected, 1'b0);
        spindle_orientation <= 1'b1;
        repeat (4) @(posedge clk);
        chk("orientation gain", gain_dynamic_selected, 1'b1);
        spindle_orientation <= 1'b0;
        wr(ADDR_DIG_POS, 32'h1234);
        for (int k = 0; k < 3; k++)
        begin
            wr(ADDR_MODE_SEL, {24'h0, 4'(k), 4'h1});
            repeat (3) @(posedge clk);
            chk("source", command_source, 4'(k));
        end
        chk("stop distance", stop_distance, 16'h1234);
        seen = 1'b0;
        photo_switch <= 1'b1;
        repeat (8)
        begin
            @(posedge clk);
            if (stop_positioning_start === 1'b1) seen = 1'b1;
        end
        chk("stop start", seen, 1'b1);
        wr(ADDR_MODE_SEL, 32'h0001);
        foreach (pcfg[i])
        begin
            reverse_run_command <= (i == 5);
            wr(ADDR_PULSE_CFG, {16'h0, pcfg[i]});
            foreach (pat[j]) src.put(pat[j]);
            repeat (3) @(posedge clk);
            exp_cnt = exp_cnt + pdel[i];
            chk("pulse count", pulse_count, exp_cnt);
        end
        rd(ADDR_COUNT);
        chk("count read", rd_data, exp_cnt);
        reverse_run_command <= 1'b0;
        wr(ADDR_MODE_SEL, 32'h1001);
        repeat (4) @(posedge clk);
        chk("servo idle", servo_running, 1'b0);
        servo_enable <= 1'b1;
        repeat (4) @(posedge clk);
        chk("servo run", servo_running, 1'b1);
        results();
    end
endmodule // tb
